// ===== rtl/fsac_top.sv
// Function
// - config select high targets ID/config region, low targets program array
// - user IDs read/write; device ID and config words read only, writes refused
// - config-space read of unlisted address clears both data bytes
// - data low holds word bits 7-0, not cleared by reset
// - data high holds word bits 13-8 in bits 5-0, top bits read zero
// - address low holds bits 7-0, cleared on reset
// - address high holds bits 14-8, cleared on reset, top bit reads one
// - latch-load-only loads latch only; otherwise load then program all latches
// - latch-load-only ignored during erase
// - erase select makes trigger erase; cleared by hardware at erase end
// - error flag set on every write-trigger set attempt, cleared on normal completion
// - program enable low inhibits every program and erase
// - write trigger set-only, self-timed, cleared by hardware at end
// - read trigger set-only, one-cycle read, cleared by hardware
// - unlock key is write-only eight bits, resets to zero
// - control top bit reads one; mode bits reset to zero
// - broken unlock sequence starts neither latch load nor write
// - latches grouped by upper ten address bits; low five select latch
// - after program write all latches return to blank 3FFF
`timescale 1ns/1ps
`include "fsac_defs.svh"

module fsac_top import fsac_pkg::*; #(
    parameter int ROW_W = 5,
    parameter int PROG_CYCLES = `FSAC_PROG_CYCLES,
    // arbitrary neutral identity value
    parameter logic [13:0] DEVICE_ID = 14'h1234
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire fsac_bus_req_type bus_req,
    output logic [7:0] read_data,
    // configuration words, read only through config space
    input wire logic [13:0] config_word_1,
    input wire logic [13:0] config_word_2,
    // status
    output logic busy
);

    localparam int ADDR_W = 15;
    localparam int ROWS_W = ADDR_W - ROW_W;
    localparam int LATCHES = 2 ** ROW_W;
    localparam logic [15:0] RUN_LAST = 16'(PROG_CYCLES - 1);

    logic [7:0] word_data_low;
    logic [5:0] word_data_high;
    logic [ADDR_W-1:0] word_address;
    fsac_ctrl_type ctrl;
    fsac_key_type key_stage;
    fsac_state_type state;
    logic [15:0] run_count;
    logic op_erase;
    logic op_cfg;
    logic op_commit;
    logic [ADDR_W-1:0] op_addr;
    logic [13:0] op_data;
    logic [13:0] flash_mem [2 ** ADDR_W];
    logic [13:0] write_latch [LATCHES];
    logic [13:0] user_id [4];

    logic hit_data_low;
    logic hit_data_high;
    logic hit_addr_low;
    logic hit_addr_high;
    logic hit_ctrl;
    logic hit_key;
    logic trigger_attempt;
    logic start_op;
    logic [13:0] read_word;
    logic [13:0] cfg_word;
    logic cfg_readable;

    function automatic logic cfg_writable(input logic [ADDR_W-1:0] a);
        cfg_writable = (a >= `FSAC_CFG_UID_FIRST) && (a <= `FSAC_CFG_UID_LAST);
    endfunction : cfg_writable

    // register decode
    always_comb begin
        hit_data_low = bus_req.write_strobe && (bus_req.addr == `FSAC_OFS_DATA_LOW);
        hit_data_high = bus_req.write_strobe && (bus_req.addr == `FSAC_OFS_DATA_HIGH);
        hit_addr_low = bus_req.write_strobe && (bus_req.addr == `FSAC_OFS_ADDR_LOW);
        hit_addr_high = bus_req.write_strobe && (bus_req.addr == `FSAC_OFS_ADDR_HIGH);
        hit_ctrl = bus_req.write_strobe && (bus_req.addr == `FSAC_OFS_CONTROL);
        hit_key = bus_req.write_strobe && (bus_req.addr == `FSAC_OFS_KEY);
        trigger_attempt = hit_ctrl && bus_req.wdata[`FSAC_BIT_WRITE_TRIG];
        // enable as stored before this write; the key must be armed by the write just before
        start_op = trigger_attempt && (key_stage == KEY_ARMED) && ctrl.program_enable
            && (state == ST_IDLE) && !ctrl.write_trigger;
    end

    // configuration space lookup
    always_comb begin
        cfg_readable = 1'b1;
        cfg_word = 14'h0000;
        if (cfg_writable(word_address)) begin
            cfg_word = user_id[word_address[1:0]];
        end else if (word_address == `FSAC_CFG_DEVICE_ID) begin
            cfg_word = DEVICE_ID;
        end else if (word_address == `FSAC_CFG_WORD_1) begin
            cfg_word = config_word_1;
        end else if (word_address == `FSAC_CFG_WORD_2) begin
            cfg_word = config_word_2;
        end else begin
            cfg_readable = 1'b0;
        end
    end

    always_comb begin
        if (ctrl.config_space_select) begin
            read_word = cfg_readable ? cfg_word : 14'h0000;
        end else begin
            read_word = flash_mem[word_address];
        end
    end

    // data registers keep their content across reset
    always_ff @(posedge clock) begin
        if (ctrl.read_trigger) begin
            word_data_high <= read_word[13:8];
            word_data_low <= read_word[7:0];
        end else begin
            if (hit_data_low) begin
                word_data_low <= bus_req.wdata;
            end
            if (hit_data_high) begin
                word_data_high <= bus_req.wdata[5:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            word_address <= `FSAC_ADDR_RESET;
        end else begin
            if (hit_addr_low) begin
                word_address[7:0] <= bus_req.wdata;
            end
            if (hit_addr_high) begin
                word_address[14:8] <= bus_req.wdata[6:0];
            end
        end
    end

    // unlock: any other write between the key bytes and the trigger disarms
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            key_stage <= KEY_IDLE;
        end else if (hit_key) begin
            if (bus_req.wdata == `FSAC_KEY_FIRST) begin
                key_stage <= KEY_FIRST;
            end else if ((bus_req.wdata == `FSAC_KEY_SECOND) && (key_stage == KEY_FIRST)) begin
                key_stage <= KEY_ARMED;
            end else begin
                key_stage <= KEY_IDLE;
            end
        end else if (bus_req.write_strobe) begin
            key_stage <= KEY_IDLE;
        end
    end

    // control: hardware clears first, software sets after, so a set in the same cycle wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
        end else begin
            if (ctrl.read_trigger) begin
                ctrl.read_trigger <= 1'b0;
            end
            if (state == ST_FINISH) begin
                ctrl.write_trigger <= 1'b0;
                if (op_erase) begin
                    ctrl.erase_select <= 1'b0;
                end
                if (!(op_cfg && !cfg_writable(op_addr))) begin
                    ctrl.sequence_error_flag <= 1'b0;
                end
            end
            if (hit_ctrl) begin
                ctrl.config_space_select <= bus_req.wdata[`FSAC_BIT_CFG_SEL];
                ctrl.latch_load_only <= bus_req.wdata[`FSAC_BIT_LATCH_ONLY];
                ctrl.erase_select <= bus_req.wdata[`FSAC_BIT_ERASE_SEL];
                ctrl.program_enable <= bus_req.wdata[`FSAC_BIT_PROG_EN];
                ctrl.sequence_error_flag <= bus_req.wdata[`FSAC_BIT_SEQ_ERR] | trigger_attempt;
                if (start_op) begin
                    ctrl.write_trigger <= 1'b1;
                end
                if (bus_req.wdata[`FSAC_BIT_READ_TRIG]) begin
                    ctrl.read_trigger <= 1'b1;
                end
            end
        end
    end

    // self-timed operation sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            run_count <= 16'h0000;
            op_erase <= 1'b0;
            op_cfg <= 1'b0;
            op_commit <= 1'b0;
            op_addr <= `FSAC_ADDR_RESET;
            op_data <= 14'h0000;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_op) begin
                        state <= ST_RUN;
                        op_erase <= ctrl.erase_select;
                        op_cfg <= ctrl.config_space_select;
                        op_commit <= !ctrl.latch_load_only || ctrl.erase_select;
                        op_addr <= word_address;
                        op_data <= {word_data_high, word_data_low};
                        // a latch-only load needs no flash time
                        run_count <= (!ctrl.latch_load_only || ctrl.erase_select) ? RUN_LAST : 16'h0000;
                    end
                end
                ST_RUN: begin
                    if (run_count == 16'h0000) begin
                        state <= ST_COMMIT;
                    end else begin
                        run_count <= run_count - 16'h0001;
                    end
                end
                ST_COMMIT: begin
                    state <= ST_FINISH;
                end
                ST_FINISH: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (start_op) begin
            busy <= 1'b1;
        end else if (state == ST_FINISH) begin
            busy <= 1'b0;
        end
    end

    // write latches of the addressed row
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < LATCHES; i++) begin
                write_latch[i] <= `FSAC_BLANK_WORD;
            end
        end else if ((state == ST_COMMIT) && op_commit && !op_cfg) begin
            for (int i = 0; i < LATCHES; i++) begin
                write_latch[i] <= `FSAC_BLANK_WORD;
            end
        end else if (start_op && !ctrl.erase_select && !ctrl.config_space_select) begin
            write_latch[word_address[ROW_W-1:0]] <= {word_data_high, word_data_low};
        end
    end

    // flash array row program or erase; never crosses the row
    always_ff @(posedge clock) begin
        if ((state == ST_COMMIT) && op_commit && !op_cfg) begin
            for (int i = 0; i < LATCHES; i++) begin
                flash_mem[{op_addr[ADDR_W-1:ROW_W], ROW_W'(i)}] <=
                    op_erase ? `FSAC_BLANK_WORD : write_latch[i];
            end
        end
    end

    // user IDs are written directly; other config words refuse writes
    always_ff @(posedge clock) begin
        if ((state == ST_COMMIT) && op_commit && op_cfg && cfg_writable(op_addr)) begin
            user_id[op_addr[1:0]] <= op_erase ? `FSAC_BLANK_WORD : op_data;
        end
    end

    // read data stands only in the cycle after the strobe; key reads zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            read_data <= 8'h00;
        end else if (bus_req.read_strobe) begin
            unique case (bus_req.addr)
                `FSAC_OFS_DATA_LOW: read_data <= word_data_low;
                `FSAC_OFS_DATA_HIGH: read_data <= {`FSAC_DATA_HIGH_TOP_VALUE, word_data_high};
                `FSAC_OFS_ADDR_LOW: read_data <= word_address[7:0];
                `FSAC_OFS_ADDR_HIGH: read_data <= {`FSAC_ADDR_HIGH_TOP_VALUE, word_address[14:8]};
                `FSAC_OFS_CONTROL: read_data <= {`FSAC_CTRL_TOP_VALUE, ctrl};
                `FSAC_OFS_KEY: read_data <= `FSAC_KEY_RESET;
                default: read_data <= 8'h00;
            endcase
        end else begin
            read_data <= 8'h00;
        end
    end

    // checks
    localparam int AST_RUN_MAX = 600;

    default clocking ast_clk @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_READ_ONE_CYCLE: assert property (
        $rose(ctrl.read_trigger) |=> !ctrl.read_trigger ##0 ({word_data_high, word_data_low} == $past(read_word))
    ) else $error("read trigger did not finish in one cycle");

    AST_CFG_UNLISTED_ZERO: assert property (
        ctrl.read_trigger && ctrl.config_space_select && !cfg_readable
        |=> (word_data_low == 8'h00) && (word_data_high == 6'h00)
    ) else $error("unlisted config read left nonzero data");

    AST_ADDR_HIGH_TOP: assert property (
        bus_req.read_strobe && (bus_req.addr == `FSAC_OFS_ADDR_HIGH) |=> read_data[7]
    ) else $error("address high top bit not one");

    AST_CTRL_TOP: assert property (
        bus_req.read_strobe && (bus_req.addr == `FSAC_OFS_CONTROL) |=> read_data[7] && (read_data[6:0] == $past(ctrl))
    ) else $error("control readback wrong");

    AST_KEY_READS_ZERO: assert property (
        bus_req.read_strobe && (bus_req.addr == `FSAC_OFS_KEY) |=> (read_data == 8'h00)
    ) else $error("key register readable");

    AST_DATA_HIGH_TOP: assert property (
        bus_req.read_strobe && (bus_req.addr == `FSAC_OFS_DATA_HIGH) |=> (read_data[7:6] == 2'h0)
    ) else $error("data high top bits not zero");

    AST_NO_START_DISABLED: assert property (
        trigger_attempt && !ctrl.program_enable && !ctrl.write_trigger |=> !ctrl.write_trigger && !busy
    ) else $error("operation started while disabled");

    AST_NO_START_UNARMED: assert property (
        trigger_attempt && (key_stage != KEY_ARMED) && !ctrl.write_trigger |=> !ctrl.write_trigger
    ) else $error("operation started without unlock");

    AST_ERR_ON_ATTEMPT: assert property (
        trigger_attempt |=> ctrl.sequence_error_flag
    ) else $error("error flag not set on trigger attempt");

    AST_WRITE_SELF_CLEAR: assert property (
        $rose(ctrl.write_trigger) |-> ctrl.write_trigger [*1] ##[1:AST_RUN_MAX] !ctrl.write_trigger
    ) else $error("write trigger never cleared");

    AST_ERASE_CLEARED: assert property (
        (state == ST_FINISH) && op_erase && !hit_ctrl |=> !ctrl.erase_select
    ) else $error("erase select not cleared after erase");

    AST_LATCH_BLANK: assert property (
        (state == ST_COMMIT) && op_commit && !op_cfg |=> (write_latch[0] == `FSAC_BLANK_WORD)
            && (write_latch[LATCHES-1] == `FSAC_BLANK_WORD)
    ) else $error("latches not blank after program");

    AST_LATCH_ONLY_FAST: assert property (
        start_op && ctrl.latch_load_only && !ctrl.erase_select |=> ##3 !busy
    ) else $error("latch-only load took flash time");

    COV_ROW_PROGRAM: cover property (
        start_op && !ctrl.latch_load_only && !ctrl.erase_select && !ctrl.config_space_select
    );

    COV_ERASE: cover property (
        start_op && ctrl.erase_select
    );

    COV_CFG_READ: cover property (
        ctrl.read_trigger && ctrl.config_space_select && cfg_readable
    );

    COV_BROKEN_KEY: cover property (
        trigger_attempt && (key_stage != KEY_ARMED)
    );

endmodule : fsac_top

// ===== shared/fsac_defs.svh
`ifndef FSAC_DEFS_SVH
`define FSAC_DEFS_SVH

// register offsets on the plain register port
`define FSAC_OFS_DATA_LOW 8'h00
`define FSAC_OFS_DATA_HIGH 8'h01
`define FSAC_OFS_ADDR_LOW 8'h02
`define FSAC_OFS_ADDR_HIGH 8'h03
`define FSAC_OFS_CONTROL 8'h04
`define FSAC_OFS_KEY 8'h05

// flash_control field positions
`define FSAC_BIT_CFG_SEL 6
`define FSAC_BIT_LATCH_ONLY 5
`define FSAC_BIT_ERASE_SEL 4
`define FSAC_BIT_SEQ_ERR 3
`define FSAC_BIT_PROG_EN 2
`define FSAC_BIT_WRITE_TRIG 1
`define FSAC_BIT_READ_TRIG 0

// fixed read values of unimplemented bits
`define FSAC_CTRL_TOP_VALUE 1'h1
`define FSAC_ADDR_HIGH_TOP_VALUE 1'h1
`define FSAC_DATA_HIGH_TOP_VALUE 2'h0

// reset values
`define FSAC_ADDR_RESET 15'h0000
`define FSAC_KEY_RESET 8'h00

// unlock pattern
`define FSAC_KEY_FIRST 8'h55
`define FSAC_KEY_SECOND 8'hAA

// blank flash word
`define FSAC_BLANK_WORD 14'h3FFF

// configuration space word addresses
`define FSAC_CFG_UID_FIRST 15'h0000
`define FSAC_CFG_UID_LAST 15'h0003
`define FSAC_CFG_DEVICE_ID 15'h0006
`define FSAC_CFG_WORD_1 15'h0007
`define FSAC_CFG_WORD_2 15'h0008

// self-timed program / erase duration
`define FSAC_CLK_PERIOD_NS 4
`define FSAC_PROG_TIME_NS 2000
`define FSAC_PROG_CYCLES ((`FSAC_PROG_TIME_NS + `FSAC_CLK_PERIOD_NS - 1) / `FSAC_CLK_PERIOD_NS)

`endif

// ===== shared/fsac_pkg.sv
package fsac_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write_strobe;
        logic read_strobe;
    } fsac_bus_req_type;

    typedef struct packed {
        logic config_space_select;
        logic latch_load_only;
        logic erase_select;
        logic sequence_error_flag;
        logic program_enable;
        logic write_trigger;
        logic read_trigger;
    } fsac_ctrl_type;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'h0,
        KEY_FIRST = 2'h1,
        KEY_ARMED = 2'h3
    } fsac_key_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1,
        ST_COMMIT = 2'h3,
        ST_FINISH = 2'h2
    } fsac_state_type;

endpackage : fsac_pkg

// ===== test/tb_top.sv
`timescale 1ns/1ps
`include "fsac_defs.svh"

module tb_top import fsac_pkg::*; ;
    localparam int PCYC = 4;
    // arbitrary identity value, not tied to any real part
    localparam logic [13:0] DEV_ID = 14'h2A5C;
    localparam logic [7:0] O_DL = `FSAC_OFS_DATA_LOW;
    localparam logic [7:0] O_DH = `FSAC_OFS_DATA_HIGH;
    localparam logic [7:0] O_AL = `FSAC_OFS_ADDR_LOW;
    localparam logic [7:0] O_AH = `FSAC_OFS_ADDR_HIGH;
    localparam logic [7:0] O_C = `FSAC_OFS_CONTROL;
    localparam logic [7:0] O_K = `FSAC_OFS_KEY;

    logic clock = 1'b0;
    logic rst = 1'b1;
    fsac_bus_req_type bus_req = '0;
    logic [7:0] read_data;
    logic [13:0] config_word_1 = 14'h0000;
    logic [13:0] config_word_2 = 14'h0000;
    logic busy;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 17087;
    int flash_m [int];
    int latch_m [32];
    int uid_m [4];

    always #2 clock = ~clock;

    fsac_top #(.PROG_CYCLES(PCYC), .DEVICE_ID(DEV_ID)) u_fsac_top (
        .clock(clock),
        .rst(rst),
        .bus_req(bus_req),
        .read_data(read_data),
        .config_word_1(config_word_1),
        .config_word_2(config_word_2),
        .busy(busy)
    );

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // caller stands just after a rising edge; the next call may drive at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, write_strobe: 1'b1, read_strobe: 1'b0};
        @(posedge clock);
    endtask : wr

    task automatic idle;
        bus_req.write_strobe <= 1'b0;
        bus_req.read_strobe <= 1'b0;
        @(posedge clock);
    endtask : idle

    task automatic rd(input string name, input logic [7:0] a, input logic [7:0] e);
        bus_req <= '{addr: a, wdata: 8'h00, write_strobe: 1'b0, read_strobe: 1'b1};
        @(posedge clock);
        bus_req.read_strobe <= 1'b0;
        #1;
        chk(name, {8'h00, e}, {8'h00, read_data});
        @(posedge clock);
    endtask : rd

    task automatic load_regs(input int a, input int d);
        wr(O_AL, a[7:0]);
        wr(O_AH, {1'b0, a[14:8]});
        wr(O_DL, d[7:0]);
        wr(O_DH, {2'b00, d[13:8]});
    endtask : load_regs

    // key pattern must be the last two writes before the trigger write
    task automatic trigger(input logic [7:0] ctl);
        wr(O_K, `FSAC_KEY_FIRST);
        wr(O_K, `FSAC_KEY_SECOND);
        wr(O_C, ctl);
    endtask : trigger

    task automatic wait_done(input string name, input int exp);
        int n;
        n = 0;
        // busy rises at the trigger edge itself, so count from there
        bus_req.write_strobe <= 1'b0;
        bus_req.read_strobe <= 1'b0;
        #1;
        while (busy === 1'b1) begin
            n++;
            if (n > 2000) begin
                mismatches++;
                $display("CHECK FAILED %s expected idle seen busy", name);
                give_verdict();
            end
            @(posedge clock);
            #1;
        end
        if (exp >= 0) begin
            chk(name, exp[15:0], n[15:0]);
        end
        @(posedge clock);
    endtask : wait_done

    task automatic read_word(input string name, input int a, input logic cfg, input int e);
        wr(O_AL, a[7:0]);
        wr(O_AH, {1'b0, a[14:8]});
        wr(O_C, {1'b0, cfg, 6'h05});
        idle();
        rd({name, " low"}, O_DL, e[7:0]);
        rd({name, " high"}, O_DH, {2'b00, e[13:8]});
    endtask : read_word

    // kind 0 programs the latches into the row, kind 1 erases the row
    task automatic m_row(input int a, input int d, input int kind);
        int r;
        r = a & 32'h7FE0;
        latch_m[a & 31] = d;
        for (int i = 0; i < 32; i++) begin
            flash_m[r | i] = (kind == 1) ? 32'h3FFF : latch_m[i];
            latch_m[i] = 32'h3FFF;
        end
    endtask : m_row

    initial begin
        int a;
        int d;
        int row;
        int row2;
        int e;
        for (int k = 0; k < 32; k++) begin
            latch_m[k] = 32'h3FFF;
        end
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        config_word_1 <= 14'($random(seed));
        config_word_2 <= 14'($random(seed));
        @(posedge clock);
        rd("address low reset", O_AL, 8'h00);
        rd("address high reset", O_AH, 8'h80);
        rd("control reset", O_C, 8'h80);
        rd("key read", O_K, 8'h00);
        rd("unmapped read", 8'h07, 8'h00);
        #1;
        chk("read data idle", 16'h0000, {8'h00, read_data});
        @(posedge clock);
        d = $random(seed);
        wr(O_DL, d[7:0]);
        wr(O_DH, d[15:8]);
        wr(O_AH, d[23:16]);
        wr(O_AL, d[31:24]);
        rd("data low", O_DL, d[7:0]);
        rd("data high", O_DH, {2'b00, d[13:8]});
        rd("address high", O_AH, {1'b1, d[22:16]});
        rd("address low", O_AL, d[31:24]);
        // three latch loads, then a programming trigger on the last word
        row = ($random(seed) & 32'h3FF) << 5;
        wr(O_C, 8'h24);
        for (int k = 0; k < 3; k++) begin
            a = row | (k * 5);
            d = $random(seed) & 32'h3FFF;
            load_regs(a, d);
            trigger(8'h26);
            wait_done("latch load busy cycles", 3);
            latch_m[a & 31] = d;
            rd("control after latch load", O_C, 8'hA4);
        end
        d = $random(seed) & 32'h3FFF;
        load_regs(row | 31, d);
        // mode bits act from their stored value, so clear latch-only before the unlock
        wr(O_C, 8'h04);
        trigger(8'h06);
        rd("control while programming", O_C, 8'h8E);
        wait_done("program end", -1);
        m_row(row | 31, d, 0);
        rd("control after program", O_C, 8'h84);
        for (int k = 0; k < 32; k++) begin
            read_word("row word", row | k, 1'b0, flash_m[row | k]);
        end
        rd("control after read", O_C, 8'h84);
        // a fresh row with one loaded latch: the rest must come back blank
        row2 = row ^ 32'h20;
        d = $random(seed) & 32'h3FFF;
        load_regs(row2 | 10, d);
        trigger(8'h06);
        wait_done("program busy cycles", PCYC + 2);
        m_row(row2 | 10, d, 0);
        read_word("second row blank", row2, 1'b0, flash_m[row2]);
        read_word("second row word", row2 | 10, 1'b0, flash_m[row2 | 10]);
        read_word("first row kept", row | 10, 1'b0, flash_m[row | 10]);
        // erase with latch-only set still runs the full timed erase
        wr(O_AL, row[7:0]);
        wr(O_AH, {1'b0, row[14:8]});
        wr(O_C, 8'h34);
        trigger(8'h36);
        wait_done("erase busy cycles", PCYC + 2);
        m_row(row, 0, 1);
        rd("control after erase", O_C, 8'hA4);
        read_word("erased word", row, 1'b0, flash_m[row]);
        read_word("erased last word", row | 31, 1'b0, flash_m[row | 31]);
        // broken key: an unrelated write between the two key values
        e = flash_m[row2 | 10];
        load_regs(row2 | 10, e ^ 32'h155);
        wr(O_K, `FSAC_KEY_FIRST);
        wr(O_AL, row2[7:0] | 8'h0A);
        wr(O_K, `FSAC_KEY_SECOND);
        wr(O_C, 8'h06);
        wait_done("broken key busy cycles", 0);
        rd("control after broken key", O_C, 8'h8C);
        read_word("word after broken key", row2 | 10, 1'b0, e);
        // enable clear: trigger refused
        wr(O_C, 8'h00);
        trigger(8'h02);
        wait_done("disabled busy cycles", 0);
        rd("control when disabled", O_C, 8'h88);
        read_word("word when disabled", row2 | 10, 1'b0, e);
        // configuration space: user words written, identity word refused
        wr(O_C, 8'h44);
        for (int k = 0; k < 4; k++) begin
            d = $random(seed) & 32'h3FFF;
            load_regs(k, d);
            trigger(8'h46);
            wait_done("user word write", -1);
            uid_m[k] = d;
        end
        load_regs(6, 32'h0155);
        trigger(8'h46);
        wait_done("identity write", -1);
        rd("control after refused write", O_C, 8'hCC);
        for (int k = 0; k < 11; k++) begin
            a = (k == 10) ? 32'h0100 : k;
            e = (k < 4) ? uid_m[k] : (k == 6) ? DEV_ID : (k == 7) ? config_word_1 :
                (k == 8) ? config_word_2 : 0;
            read_word("config space word", a, 1'b1, e);
        end
        read_word("config word 2 again", 8, 1'b1, config_word_2);
        read_word("array beside config", row2 | 10, 1'b0, flash_m[row2 | 10]);
        // second reset: address clears, data low byte is kept
        e = flash_m[row2 | 10];
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd("data low after reset", O_DL, e[7:0]);
        rd("address low after reset", O_AL, 8'h00);
        rd("control after reset", O_C, 8'h80);
        give_verdict();
    end
endmodule : tb_top
